// file: fis_pkg.sv
// Package for the fault interrupt status block: field positions, widths, types.
// Assumes a single device clock domain; nothing here holds state.
package fis_pkg;
   localparam int unsigned NUM_CHANNELS = 4;
   localparam int unsigned STATUS_WIDTH = 16;
   // Field positions in the status word
   localparam int unsigned OVC_LSB = 8;
   localparam int unsigned SHDN_BIT = 5;
   localparam int unsigned WARN_BIT = 4;
   localparam int unsigned SUPPLY_BIT = 3;
   localparam int unsigned TMOUT_BIT = 2;
   localparam int unsigned GPIO_BIT = 1;
   localparam int unsigned CRC_BIT = 0;
   // Minimum frame lengths for a properly formatted transaction
   localparam int unsigned MIN_BITS_NO_CRC = 24;
   localparam int unsigned MIN_BITS_CRC = 32;
   localparam int unsigned BIT_CNT_WIDTH = 6;
   // Reset value of the status word and of the power enables
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [3:0] PWR_RESET = 4'h0;
   localparam logic [3:0] PWR_ALL_OFF = 4'h0;
   // Analog sense inputs grouped together
   typedef struct packed {
      logic [3:0] overcurrent;    // Per channel current above limit
      logic [3:0] voltage_mode;   // Per channel voltage output mode
      logic [3:0] amp_powered;    // Per channel amplifier powered
      logic temp_above_shdn;      // Die above shutdown threshold
      logic temp_above_warn;      // Die above warning rise threshold
      logic temp_below_release;   // Die below warning release threshold
      logic supply_low;           // High supply below threshold
   } fis_sense_type;
   // Serial frame activity
   typedef struct packed {
      logic cs_release;           // One cycle pulse at end of frame
      logic bit_strobe;           // One cycle pulse per shifted bit
      logic crc_enable;           // CRC mode active
      logic crc_error;            // Pulse on detected CRC error
   } fis_serial_type;
endpackage

// file: fis_fault_interrupt_status.sv
// Fault interrupt status register with flags, clear policies and interrupt pin.
// Assumes sense inputs already synchronous to i_sys_clk; timeout period given
// in cycles by the surrounding configuration logic.
// Outputs change one edge after the cause; a read clears at the edge that
// samples it, so the host takes the word in the read cycle itself.
// Clear-on-read flags give way to a fresh event in the same cycle, so a
// read never swallows a fault; the host sees it again on its next read.
// Level flags (warning, supply, auto-mode overcurrent) ignore reads.
// The timeout watch counts clock cycles, not serial bit times.
`timescale 1ns/1ps
module fis_fault_interrupt_status #(
   parameter int unsigned TIMEOUT_WIDTH = 24
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Sense and serial activity
   input wire fis_pkg::fis_sense_type i_sense,
   input wire fis_pkg::fis_serial_type i_serial,
   input wire logic i_gpio_edge,
   input wire logic i_gpio_edge_enable,
   // Configuration
   input wire logic i_overcurrent_clear_policy,
   input wire logic [TIMEOUT_WIDTH-1:0] i_timeout_cycles,
   input wire logic i_timeout_enable,
   input wire logic [15:0] i_int_enable,
   // Status read and power control
   input wire logic i_status_read,
   input wire logic i_power_write,
   input wire logic [3:0] i_power_wdata,
   output logic [15:0] o_status,
   output logic [3:0] o_channel_power_enables,
   output logic o_int_n
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   // Flag registers
   logic [3:0] overcurrent_flag_reg, overcurrent_flag_next;
   logic overtemp_shutdown_flag_reg, overtemp_shutdown_flag_next;
   logic overtemp_warning_flag_reg, overtemp_warning_flag_next;
   logic high_supply_low_flag_reg, high_supply_low_flag_next;
   logic serial_timeout_flag_reg, serial_timeout_flag_next;
   logic gpio_edge_flag_reg, gpio_edge_flag_next;
   logic crc_flag_reg, crc_flag_next;

   // Power enables and frame counters
   logic [3:0] channel_power_enables_reg, channel_power_enables_next;
   logic [fis_pkg::BIT_CNT_WIDTH-1:0] bit_cnt_reg, bit_cnt_next;
   logic [TIMEOUT_WIDTH-1:0] idle_cnt_reg, idle_cnt_next;

   // Registered outputs
   logic [15:0] status_reg, status_next;
   logic int_n_reg, int_n_next;

   // Combinational helpers
   logic [15:0] flags;
   logic [3:0] oc_event;
   logic frame_ok;
   logic timeout_hit;

   // Set wins over clear-on-read
   // Shared by every clear-on-read flag so all use one priority
   function automatic logic sticky(input logic flag, input logic set, input logic rd);
      sticky = set | (flag & ~rd);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Flag and counter next state
   always_comb
   begin
      oc_event = i_sense.overcurrent & i_sense.voltage_mode;
      // Length is judged on the count held when chip select releases
      // frame length check
      frame_ok = i_serial.crc_enable ?
         (bit_cnt_reg >= fis_pkg::BIT_CNT_WIDTH'(fis_pkg::MIN_BITS_CRC)) :
         (bit_cnt_reg >= fis_pkg::BIT_CNT_WIDTH'(fis_pkg::MIN_BITS_NO_CRC));
      // Timeout stays up while idle, so only a proper frame lifts it
      timeout_hit = i_timeout_enable && (idle_cnt_reg >= i_timeout_cycles);
      // Bit counter saturates so long frames stay counted as proper
      // Limitation: a strobe in the release cycle itself is not counted
      bit_cnt_next = bit_cnt_reg;
      if (i_serial.cs_release)
         bit_cnt_next = '0;
      else if (i_serial.bit_strobe && (bit_cnt_reg != '1))
         bit_cnt_next = bit_cnt_reg + 1'b1;
      // Saturates so a long disabled spell cannot wrap to a short count
      // restart only at frame end
      idle_cnt_next = idle_cnt_reg;
      if (i_serial.cs_release && frame_ok)
         idle_cnt_next = '0;
      else if (!timeout_hit && (idle_cnt_reg != '1))
         idle_cnt_next = idle_cnt_reg + 1'b1;
      // Auto mode watches the amplifier sense, not the power enables,
      // because the amplifier restarts by itself once the fault is gone
      // auto mode clears when resolved and powered
      // host mode clears only on read
      for (int i = 0; i < fis_pkg::NUM_CHANNELS; i++)
      begin
         if (i_overcurrent_clear_policy)
            overcurrent_flag_next[i] = sticky(overcurrent_flag_reg[i], oc_event[i],
               i_status_read);
         else
            overcurrent_flag_next[i] = oc_event[i] |
               (overcurrent_flag_reg[i] & ~i_sense.amp_powered[i]);
      end
      overtemp_shutdown_flag_next = sticky(overtemp_shutdown_flag_reg,
         i_sense.temp_above_shdn, i_status_read);
      // Two comparator levels give the hysteresis; no timer here
      // warning with hysteresis
      overtemp_warning_flag_next = i_sense.temp_above_warn |
         (overtemp_warning_flag_reg & ~i_sense.temp_below_release);
      // No latch: a dip shorter than one cycle goes unseen
      // supply low follows level
      high_supply_low_flag_next = i_sense.supply_low;
      serial_timeout_flag_next = sticky(serial_timeout_flag_reg, timeout_hit,
         i_status_read);
      gpio_edge_flag_next = sticky(gpio_edge_flag_reg,
         i_gpio_edge & i_gpio_edge_enable, i_status_read);
      crc_flag_next = sticky(crc_flag_reg,
         i_serial.crc_error & i_serial.crc_enable, i_status_read);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power enables, status word, interrupt pin
   always_comb
   begin
      // Priority: host write, then overcurrent, then shutdown on top
      channel_power_enables_next = channel_power_enables_reg;
      if (i_power_write)
         channel_power_enables_next = i_power_wdata;
      // host mode powers down faulted channel
      if (i_overcurrent_clear_policy)
         channel_power_enables_next = channel_power_enables_next & ~oc_event;
      if (i_sense.temp_above_shdn)
         channel_power_enables_next = fis_pkg::PWR_ALL_OFF;

      // Word built from next values so it always equals the flag registers
      // overcurrent field placement
      flags = '0;
      flags[fis_pkg::OVC_LSB +: fis_pkg::NUM_CHANNELS] = overcurrent_flag_next;
      flags[fis_pkg::SHDN_BIT] = overtemp_shutdown_flag_next;
      flags[fis_pkg::WARN_BIT] = overtemp_warning_flag_next;
      flags[fis_pkg::SUPPLY_BIT] = high_supply_low_flag_next;
      flags[fis_pkg::TMOUT_BIT] = serial_timeout_flag_next;
      flags[fis_pkg::GPIO_BIT] = gpio_edge_flag_next;
      flags[fis_pkg::CRC_BIT] = crc_flag_next;
      status_next = flags;
      int_n_next = ~|(flags & i_int_enable);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers only
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         // Flags start from the package reset word, the pin idles high
         overcurrent_flag_reg <= fis_pkg::STATUS_RESET[fis_pkg::OVC_LSB +: fis_pkg::NUM_CHANNELS];
         overtemp_shutdown_flag_reg <= fis_pkg::STATUS_RESET[fis_pkg::SHDN_BIT];
         overtemp_warning_flag_reg <= fis_pkg::STATUS_RESET[fis_pkg::WARN_BIT];
         high_supply_low_flag_reg <= fis_pkg::STATUS_RESET[fis_pkg::SUPPLY_BIT];
         serial_timeout_flag_reg <= fis_pkg::STATUS_RESET[fis_pkg::TMOUT_BIT];
         gpio_edge_flag_reg <= fis_pkg::STATUS_RESET[fis_pkg::GPIO_BIT];
         crc_flag_reg <= fis_pkg::STATUS_RESET[fis_pkg::CRC_BIT];
         channel_power_enables_reg <= fis_pkg::PWR_RESET;
         bit_cnt_reg <= '0;
         idle_cnt_reg <= '0;
         status_reg <= fis_pkg::STATUS_RESET;
         int_n_reg <= '1;
      end
      else
      begin
         overcurrent_flag_reg <= overcurrent_flag_next;
         overtemp_shutdown_flag_reg <= overtemp_shutdown_flag_next;
         overtemp_warning_flag_reg <= overtemp_warning_flag_next;
         high_supply_low_flag_reg <= high_supply_low_flag_next;
         serial_timeout_flag_reg <= serial_timeout_flag_next;
         gpio_edge_flag_reg <= gpio_edge_flag_next;
         crc_flag_reg <= crc_flag_next;
         channel_power_enables_reg <= channel_power_enables_next;
         bit_cnt_reg <= bit_cnt_next;
         idle_cnt_reg <= idle_cnt_next;
         status_reg <= status_next;
         int_n_reg <= int_n_next;
      end
   end

   // Outputs straight from flops
   // so the pin and the word never glitch between edges
   assign o_status = status_reg;
   assign o_channel_power_enables = channel_power_enables_reg;
   assign o_int_n = int_n_reg;

endmodule

// file: fis_chk.sv
// Checker for the fault interrupt status block: flag timing, power, pin.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ps
module fis_chk
(
   // Clock, reset and inputs
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire fis_pkg::fis_sense_type i_sense,
   input wire logic i_overcurrent_clear_policy,
   input wire logic [15:0] i_int_enable,
   input wire logic i_status_read,
   // Design outputs
   input wire logic [15:0] o_status,
   input wire logic [3:0] o_channel_power_enables,
   input wire logic o_int_n
);
   // Past values are guarded since flags restart from zero after reset
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////
   rsvd_zero_a: assert property (o_status[15:12] == 4'h0 && o_status[7:6] == 2'h0)
      else $error("reserved status bits set");
   shdn_set_a: assert property (i_sense.temp_above_shdn |=>
      o_status[5] && o_channel_power_enables == 4'h0) else $error("shutdown not taken");
   shdn_clr_a: assert property (o_status[5] && i_status_read &&
      !i_sense.temp_above_shdn |=> !o_status[5]) else $error("shutdown flag kept");
   warn_set_a: assert property (i_sense.temp_above_warn |=> o_status[4])
      else $error("warning flag missed");
   supply_follow_a: assert property (!$past(i_reset) |->
      o_status[3] == $past(i_sense.supply_low)) else $error("supply flag wrong");
   ovc_cause_a: assert property (!$past(i_reset) |-> (o_status[11:8] &
      ~$past(o_status[11:8]) & ~$past(i_sense.overcurrent & i_sense.voltage_mode)) == 4'h0)
      else $error("overcurrent flag without cause");
   ovc_power_off_a: assert property (i_overcurrent_clear_policy &&
      |(i_sense.overcurrent & i_sense.voltage_mode) |=> (o_channel_power_enables &
      $past(i_sense.overcurrent & i_sense.voltage_mode)) == 4'h0) else $error("no power down");
   int_pin_a: assert property (!$past(i_reset) |->
      o_int_n == !(|(o_status & $past(i_int_enable)))) else $error("interrupt pin wrong");
endmodule
bind fis_fault_interrupt_status fis_chk i_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
   .i_sense(i_sense), .i_overcurrent_clear_policy(i_overcurrent_clear_policy),
   .i_int_enable(i_int_enable), .i_status_read(i_status_read), .o_status(o_status),
   .o_channel_power_enables(o_channel_power_enables), .o_int_n(o_int_n));

// file: fis_host.sv
// Host model: sends a serial frame of a given bit count, one bit a cycle.
// Assumes the bench pulses i_go for one cycle while no frame runs.
`timescale 1ns/1ps
module fis_host
(
   // Clock and request
   input wire logic i_sys_clk,
   input wire logic i_go,
   input wire logic [5:0] i_nbits,
   // Frame activity
   output logic o_bit_strobe,
   output logic o_cs_release
);
   initial
   begin
      o_bit_strobe = 1'b0;
      o_cs_release = 1'b0;
      forever
      begin
         @(posedge i_sys_clk);
         if (i_go)
         begin
            repeat (i_nbits) @(posedge i_sys_clk) o_bit_strobe <= 1'b1;
            @(posedge i_sys_clk) o_bit_strobe <= 1'b0;
            o_cs_release <= 1'b1;
            @(posedge i_sys_clk) o_cs_release <= 1'b0;
         end
      end
   end
endmodule

// file: fis_fault_interrupt_status_tb_top.sv
// Bench for the fault interrupt status block: sense steps, reads, frames.
// Assumes a 200 MHz clock and the host model for serial frames.
`timescale 1ns/1ps
module fis_fault_interrupt_status_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0, cre = 1'b0, pol = 1'b0, ten = 1'b0, pw = 1'b0, go = 1'b0, bs, cs;
   logic [1:0] ev = 2'h0;
   logic [5:0] nb = 6'h00;
   logic [15:0] sen = 16'h0000;
   // Interrupt mask starts with the warning bit only; gpio edges enabled
   logic [15:0] ien = 16'h0010;
   logic gen = 1'b1;
   int num_errors = 0, checked = 0, cyc = 0;
   fis_pkg::fis_serial_type ser;
   assign ser = {cs, bs, cre, ev[0]};
   // Free running clock and a hang guard
   always #2.5 clk = ~clk;
   // Ceiling about ten times the planned run of some two hundred cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         num_errors++;
         results();
      end
   end
   fis_host i_host (.i_sys_clk(clk), .i_go(go), .i_nbits(nb), .o_bit_strobe(bs),
      .o_cs_release(cs));
   fis_fault_interrupt_status #(.TIMEOUT_WIDTH(24)) i_dut (.i_sys_clk(clk), .i_reset(rst),
      .i_sense(sen), .i_serial(ser), .i_gpio_edge(ev[1]), .i_gpio_edge_enable(gen),
      .i_overcurrent_clear_policy(pol), .i_timeout_cycles(24'h000014),
      .i_timeout_enable(ten), .i_int_enable(ien), .i_status_read(rd),
      .i_power_write(pw), .i_power_wdata(4'hf), .o_status(), .o_channel_power_enables(),
      .o_int_n());
   ////////////////////////////////////////
   task w(input int n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t: %h not %h", $time, got, exp);
      end
   endtask
   // One sensed step, sampled after the edge that takes it
   task st(input logic [15:0] s, input logic r, input logic [1:0] e, input logic [15:0] exp);
      w(1);
      sen <= s;
      rd <= r;
      ev <= e;
      w(1);
      rd <= 1'b0;
      ev <= 2'h0;
      #1 chk(i_dut.o_status, exp);
   endtask
   task fr(input logic [5:0] n, input logic c, input logic [15:0] exp);
      w(1);
      cre <= c;
      nb <= n;
      go <= 1'b1;
      w(1);
      go <= 1'b0;
      w(n + 2);
      st(16'h0000, 1'b1, 2'h0, exp);
   endtask
   task power_on();
      w(1);
      pw <= 1'b1;
      w(1);
      pw <= 1'b0;
   endtask
   task results();
      $display("checks %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Sense layout: overcurrent, voltage mode, powered, then shdn warn release supply
   initial
   begin
      w(3);
      rst <= 1'b0;
      #1 chk(i_dut.o_status, 16'h0000);
      chk({15'h0, i_dut.o_int_n}, 16'h0001);
      st(16'h4000, 1'b0, 2'h0, 16'h0000);
      st(16'h4400, 1'b0, 2'h0, 16'h0400);
      chk({15'h0, i_dut.o_int_n}, 16'h0001);
      st(16'h0400, 1'b0, 2'h0, 16'h0400);
      st(16'h0440, 1'b0, 2'h0, 16'h0000);
      st(16'h0004, 1'b0, 2'h0, 16'h0010);
      chk({15'h0, i_dut.o_int_n}, 16'h0000);
      st(16'h0000, 1'b0, 2'h0, 16'h0010);
      st(16'h0002, 1'b0, 2'h0, 16'h0000);
      st(16'h0001, 1'b0, 2'h0, 16'h0008);
      chk({15'h0, i_dut.o_int_n}, 16'h0001);
      st(16'h0000, 1'b0, 2'h0, 16'h0000);
      $display("test level flags done");
      w(1);
      ien <= 16'hffff;
      power_on();
      #1 chk({12'h0, i_dut.o_channel_power_enables}, 16'h000f);
      st(16'h0008, 1'b0, 2'h0, 16'h0020);
      chk({12'h0, i_dut.o_channel_power_enables}, 16'h0000);
      chk({15'h0, i_dut.o_int_n}, 16'h0000);
      st(16'h0008, 1'b1, 2'h0, 16'h0020);
      st(16'h0000, 1'b1, 2'h0, 16'h0000);
      w(1);
      gen <= 1'b0;
      st(16'h0000, 1'b0, 2'h3, 16'h0000);
      w(1);
      cre <= 1'b1;
      gen <= 1'b1;
      st(16'h0000, 1'b0, 2'h3, 16'h0003);
      st(16'h0000, 1'b1, 2'h0, 16'h0000);
      $display("test clear on read done");
      w(1);
      pol <= 1'b1;
      power_on();
      st(16'h2200, 1'b0, 2'h0, 16'h0200);
      chk({12'h0, i_dut.o_channel_power_enables}, 16'h000d);
      st(16'h0000, 1'b0, 2'h0, 16'h0200);
      st(16'h0000, 1'b1, 2'h0, 16'h0000);
      $display("test host policy done");
      w(1);
      ten <= 1'b1;
      fr(6'd24, 1'b0, 16'h0000);
      fr(6'd23, 1'b0, 16'h0004);
      fr(6'd31, 1'b1, 16'h0004);
      fr(6'd32, 1'b1, 16'h0000);
      $display("test timeout done");
      results();
   end
endmodule
